// ### common/acs_defines.vh
// Register map, field positions and reset values of the channel/setup bank
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
`define ACS_CH_BASE 8'h10
`define ACS_SETUP_BASE 8'h20
`define ACS_SETUP_LAST 8'h27
`define ACS_CH_RESET 16'h8001
`define ACS_CH0_RESET 16'h8001
`define ACS_CHN_RESET 16'h0001
`define ACS_SETUP_RESET 16'h1000
`define ACS_SETUP_WMASK 16'h1f30
`define ACS_CH_WMASK 16'hf3ff
`define ACS_CODING_BIT 12
`define ACS_REFP_BIT 11
`define ACS_REFN_BIT 10
`define ACS_INBUF_HI 9
`define ACS_INBUF_LO 8
`define ACS_REFSEL_HI 5
`define ACS_REFSEL_LO 4
`define ACS_SETUP_IDX_HI 14
`define ACS_SETUP_IDX_LO 12
`define ACS_INSEL_HI 9
`define ACS_INSEL_LO 0
`define ACS_INSEL_TEMP 10'h232
`define ACS_INSEL_REF 10'h2b6
`define ACS_COM_CODE 5'h10
`define ACS_LOW_COM 5'h0f
`define ACS_REF_EXT 2'h0
`define ACS_REF_INT 2'h2
`define ACS_REF_SUP 2'h3
`define ACS_INBUF_OFF 2'h0
`define ACS_INBUF_ON 2'h3
`endif

// ### rtl/acs_reg_mem.v
// Small register memory with registered read data and write mask
`timescale 1ns/10ps
module acs_reg_mem #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter [15:0] WMASK = 16'hffff
)(
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] rst_val_i,
  input wire [15:0] rst_val0_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire [15:0] wdata_i,
  input wire [AW-1:0] raddr_i,
  output reg [15:0] rdata_o,
  input wire [AW-1:0] laddr_i,
  output reg [15:0] ldata_o
);
  reg [15:0] mem_q [0:DEPTH-1];
  integer k;

  // Reset loads defaults; masked bits stay zero forever
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (k = 0; k < DEPTH; k = k + 1)
        mem_q[k] <= (k == 0) ? rst_val0_i : rst_val_i;
    end
    else if (we_i)
      mem_q[waddr_i] <= wdata_i & WMASK;
  end

  // Registered read ports, bus side and conversion side
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 16'h0000;
      ldata_o <= 16'h0000;
    end
    else
    begin
      rdata_o <= mem_q[raddr_i];
      ldata_o <= mem_q[laddr_i];
    end
  end
endmodule // acs_reg_mem

// ### rtl/acs_input_decode.v
// Decodes an input selection code into positive and negative input numbers
`timescale 1ns/10ps
`include "acs_defines.vh"
module acs_input_decode (
  input wire [9:0] code_i,
  output reg [4:0] pos_o,
  output reg [4:0] neg_o,
  output reg temp_o,
  output reg ref_o,
  output reg single_o,
  output reg valid_o
);
  // Code is two 5-bit fields: positive in [9:5], negative in [4:0]
  always @*
  begin
    pos_o = code_i[9:5];
    neg_o = code_i[4:0];
    temp_o = (code_i == `ACS_INSEL_TEMP);
    ref_o = (code_i == `ACS_INSEL_REF);
    single_o = (code_i[4:0] == `ACS_COM_CODE) ||
      (code_i[4:0] == `ACS_LOW_COM);
    valid_o = temp_o || ref_o ||
      ((code_i[9:5] < 5'd15) && (code_i[4:0] <= 5'd16) &&
      (code_i[9:5] != code_i[4:0]));
  end
endmodule // acs_input_decode

// ### rtl/acs_config_bank.v
// Channel input selection and setup configuration register bank
//
// Functional notes
// - Each channel holds 10-bit input selection, bits 9:0, reset 0x1.
// - Input paired with common code gives single-ended measurement.
// - Low-level inputs against input fifteen are pseudo-differential.
// - Eight 16-bit setup registers at 0x20..0x27, reset 0x1000.
// - Bit 12 selects coding, 1 bipolar, default bipolar.
// - Bit 11 enables positive reference buffer, reset off.
// - Bit 10 enables negative reference buffer, reset off.
// - Bits 9:8 input buffers, 00 off, 11 on; host avoids 01/10.
// - Bits 5:4 reference: 00 external, 10 internal, 11 supply.
// - Reserved setup bits read zero; host writes zeros.
// - Channel 3-bit setup index picks which setup applies.
`timescale 1ns/10ps
`include "acs_defines.vh"
module acs_config_bank #(
  parameter NUM_CH = 16,
  parameter NUM_SETUP = 8
)(
  input wire clk_i,
  input wire rst_i,
  // Classic Wishbone slave, byte address
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  output wire err_o,
  // Conversion side: channel to convert
  input wire conv_start_i,
  input wire [3:0] conv_ch_i,
  output reg conv_valid_o,
  output reg [4:0] conv_pos_o,
  output reg [4:0] conv_neg_o,
  output reg conv_temp_o,
  output reg conv_ref_o,
  output reg conv_single_o,
  output reg conv_bad_input_o,
  output reg conv_bipolar_o,
  output reg conv_refp_buf_o,
  output reg conv_refn_buf_o,
  output reg conv_inbuf_o,
  output reg [1:0] conv_ref_sel_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_ACK = 2'd2;
  localparam CV_IDLE = 2'd0;
  localparam CV_CH = 2'd1;
  localparam CV_SETUP = 2'd2;
  localparam CV_OUT = 2'd3;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg err_q;
  reg [1:0] cv_q;
  reg [3:0] cv_ch_q;
  wire [15:0] ch_rdata;
  wire [15:0] ch_ldata;
  wire [15:0] su_rdata;
  wire [15:0] su_ldata;
  wire [4:0] dec_pos;
  wire [4:0] dec_neg;
  wire dec_temp;
  wire dec_ref;
  wire dec_single;
  wire dec_valid;

  // Address decode helpers
  function is_ch;
    input [7:0] a;
    begin
      is_ch = ((a >> 4) == (`ACS_CH_BASE >> 4));
    end
  endfunction

  function is_setup;
    input [7:0] a;
    begin
      is_setup = (a >= `ACS_SETUP_BASE) && (a <= `ACS_SETUP_LAST);
    end
  endfunction

  // Register offsets are word indexes: byte address is four times offset
  wire [5:0] widx = adr_i[7:2];
  wire [7:0] ridx = {2'b00, widx};
  wire hit_ch = is_ch(ridx);
  wire hit_su = is_setup(ridx);
  wire req = cyc_i && stb_i && (st_q == ST_IDLE);
  // Writes need the low two byte lanes; partial lanes are ignored
  wire wr_ok = req && we_i && (sel_i[1:0] == 2'b11);
  wire ch_we = wr_ok && hit_ch;
  wire su_we = wr_ok && hit_su;

  // Bus FSM: one wait state for registered read data, then ack
  always @*
  begin
    case (st_q)
      ST_IDLE: st_d = (cyc_i && stb_i) ? ST_WAIT : ST_IDLE;
      ST_WAIT: st_d = ST_ACK;
      ST_ACK: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_IDLE;
      err_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (req)
        err_q <= !(hit_ch || hit_su);
    end
  end

  assign ack_o = (st_q == ST_ACK) && cyc_i && stb_i && !err_q;
  assign err_o = (st_q == ST_ACK) && cyc_i && stb_i && err_q;

  // Read data, narrow registers in low half, reserved bits zero
  always @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (st_q == ST_WAIT)
    begin
      if (hit_ch)
        dat_o <= {16'h0000, ch_rdata};
      else if (hit_su)
        dat_o <= {16'h0000, su_rdata & `ACS_SETUP_WMASK};
      else
        dat_o <= 32'h00000000;
    end
  end

  // Channel registers: enable, setup index, input selection
  acs_reg_mem #(
    .DEPTH(NUM_CH),
    .AW(4),
    .WMASK(`ACS_CH_WMASK)
  ) u_ch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rst_val_i(`ACS_CHN_RESET),
    .rst_val0_i(`ACS_CH0_RESET),
    .we_i(ch_we),
    .waddr_i(widx[3:0]),
    .wdata_i(dat_i[15:0]),
    .raddr_i(widx[3:0]),
    .rdata_o(ch_rdata),
    .laddr_i(cv_ch_q),
    .ldata_o(ch_ldata)
  );

  // Setup configuration registers, reserved bits masked off on write
  acs_reg_mem #(
    .DEPTH(NUM_SETUP),
    .AW(3),
    .WMASK(`ACS_SETUP_WMASK)
  ) u_setup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .rst_val_i(`ACS_SETUP_RESET),
    .rst_val0_i(`ACS_SETUP_RESET),
    .we_i(su_we),
    .waddr_i(widx[2:0]),
    .wdata_i(dat_i[15:0]),
    .raddr_i(widx[2:0]),
    .rdata_o(su_rdata),
    .laddr_i(ch_ldata[`ACS_SETUP_IDX_HI:`ACS_SETUP_IDX_LO]),
    .ldata_o(su_ldata)
  );

  // Input code decode of the channel under conversion
  acs_input_decode u_dec (
    .code_i(ch_ldata[`ACS_INSEL_HI:`ACS_INSEL_LO]),
    .pos_o(dec_pos),
    .neg_o(dec_neg),
    .temp_o(dec_temp),
    .ref_o(dec_ref),
    .single_o(dec_single),
    .valid_o(dec_valid)
  );

  // Conversion lookup: channel read, then setup read, then outputs.
  // Setup is fetched at each start, so fresh writes apply next time.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cv_q <= CV_IDLE;
      cv_ch_q <= 4'h0;
      conv_valid_o <= 1'b0;
      conv_pos_o <= 5'h00;
      conv_neg_o <= 5'h00;
      conv_temp_o <= 1'b0;
      conv_ref_o <= 1'b0;
      conv_single_o <= 1'b0;
      conv_bad_input_o <= 1'b0;
      conv_bipolar_o <= 1'b1;
      conv_refp_buf_o <= 1'b0;
      conv_refn_buf_o <= 1'b0;
      conv_inbuf_o <= 1'b0;
      conv_ref_sel_o <= `ACS_REF_EXT;
    end
    else
    begin
      conv_valid_o <= 1'b0;
      case (cv_q)
        CV_IDLE:
        begin
          if (conv_start_i)
          begin
            cv_ch_q <= conv_ch_i;
            cv_q <= CV_CH;
          end
        end
        CV_CH: cv_q <= CV_SETUP;
        CV_SETUP: cv_q <= CV_OUT;
        CV_OUT:
        begin
          conv_valid_o <= 1'b1;
          conv_pos_o <= dec_pos;
          conv_neg_o <= dec_neg;
          conv_temp_o <= dec_temp;
          conv_ref_o <= dec_ref;
          conv_single_o <= dec_single;
          conv_bad_input_o <= !dec_valid;
          conv_bipolar_o <= su_ldata[`ACS_CODING_BIT];
          conv_refp_buf_o <= su_ldata[`ACS_REFP_BIT];
          conv_refn_buf_o <= su_ldata[`ACS_REFN_BIT];
          // Reserved codes 01/10 treated as off
          conv_inbuf_o <= (su_ldata[`ACS_INBUF_HI:`ACS_INBUF_LO] ==
            `ACS_INBUF_ON);
          conv_ref_sel_o <= su_ldata[`ACS_REFSEL_HI:`ACS_REFSEL_LO];
          cv_q <= CV_IDLE;
        end
        default: cv_q <= CV_IDLE;
      endcase
    end
  end
endmodule // acs_config_bank

// ### verif/acs_chk_properties.sv
// Bus and conversion timing checker for the config bank
`timescale 1ns/10ps
module acs_chk (
  input wire clk_i,
  input wire rst_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire conv_start_i,
  input wire conv_valid_o,
  input wire [4:0] conv_neg_o,
  input wire conv_single_o,
  input wire conv_temp_o,
  input wire conv_ref_o,
  input wire conv_bipolar_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer timing and address decode
  ack_lat_a: assert property ($rose(stb_i) |-> ##2 (ack_o || err_o))
    else $error("bus answer not in cycle two");
  ack_once_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  err_map_a: assert property (err_o |->
    (adr_i[7:2] < 6'h10 || adr_i[7:2] > 6'h27))
    else $error("mapped word refused");
  rsv_zero_a: assert property (ack_o && !we_i && adr_i[7:5] == 3'h4
    |-> (dat_o & 32'hffffe0cf) == 32'h0)
    else $error("reserved setup bits read nonzero");
  // Conversion result timing and flags
  conv_lat_a: assert property (conv_valid_o |-> $past(conv_start_i, 4))
    else $error("result not four cycles after start");
  valid_once_a: assert property (conv_valid_o |=> !conv_valid_o)
    else $error("result valid too long");
  single_neg_a: assert property (conv_single_o
    |-> conv_neg_o inside {5'h10, 5'h0f})
    else $error("single-ended without common input");
  temp_ref_a: assert property (conv_temp_o |-> !conv_ref_o)
    else $error("sensor and reference both selected");
  coding_hold_a: assert property (!conv_valid_o |-> $stable(conv_bipolar_o))
    else $error("coding changed between results");
  cover property (conv_valid_o && conv_single_o);
  cover property (err_o);
  cover property (ack_o && we_i);
endmodule // acs_chk

bind acs_config_bank acs_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .conv_start_i(conv_start_i), .conv_valid_o(conv_valid_o),
  .conv_neg_o(conv_neg_o), .conv_single_o(conv_single_o),
  .conv_temp_o(conv_temp_o), .conv_ref_o(conv_ref_o),
  .conv_bipolar_o(conv_bipolar_o));

// ### verif/adc_channel_input_and_setup_config_test.sv
// Self-checking bench of the channel and setup register bank
`timescale 1ns/10ps
`define CHK(n, e, s) \
  begin \
    n_compared++; \
    if ((e) !== (s)) \
    begin \
      n_fail++; \
      $display("BAD %s exp %h seen %h", n, e, s); \
    end \
  end
module adc_channel_input_and_setup_config_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cs = 0, f;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, cch = 0;
  logic [31:0] dat = 0, rd;
  logic [15:0] d, sm [8], cm [16];
  logic [9:0] cd [8] = '{10'h001, 10'h150, 10'h16c, 10'h16f, 10'h1cf,
    10'h232, 10'h2b6, 10'h3ff};
  wire [31:0] dat_o;
  wire ack, err, vld, tmp, rf, sgl, bad, bip, rp, rn, ib;
  wire [4:0] pos, neg;
  wire [1:0] rsel;
  int n_fail = 0, n_compared = 0, i, k;

  // Device under test
  acs_config_bank dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .err_o(err), .conv_start_i(cs),
    .conv_ch_i(cch), .conv_valid_o(vld), .conv_pos_o(pos),
    .conv_neg_o(neg), .conv_temp_o(tmp), .conv_ref_o(rf),
    .conv_single_o(sgl), .conv_bad_input_o(bad), .conv_bipolar_o(bip),
    .conv_refp_buf_o(rp), .conv_refn_buf_o(rn), .conv_inbuf_o(ib),
    .conv_ref_sel_o(rsel));

  // 10 MHz clock
  initial forever #50 clk_i = ~clk_i;

  task end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Classic cycle; request held until the edge that sees the answer
  task wb(input logic w, input logic [7:0] a, input logic [15:0] v,
    input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, 16'h0, v, s};
    @(posedge clk_i);
    for (k = 0; k < 9 && (ack | err) !== 1'b1; k++) @(posedge clk_i);
    if (k == 9) n_fail++;
    rd = dat_o;
    f = err;
    {cyc, stb} <= 2'h0;
  endtask

  // Write through and update the model with the writable fields
  task wr(input logic [7:0] a, input logic [15:0] v);
    wb(1, a, v, 4'hf);
    if (a[7]) sm[a[4:2]] = v & 16'h1f30;
    else cm[a[5:2]] = v & 16'hf3ff;
  endtask

  task rall;
    for (i = 0; i < 24; i++)
    begin
      wb(0, 8'(8'h40 + 4 * i), 16'h0, 4'hf);
      d = i < 16 ? cm[i] : sm[i - 16];
      `CHK("reg", 32'(d), rd)
    end
  endtask

  // One conversion; fields follow the channel's code and setup
  task cv(input logic [3:0] c);
    logic [15:0] h, s;
    h = cm[c];
    s = sm[h[14:12]];
    @(posedge clk_i);
    {cs, cch} <= {1'b1, c};
    @(posedge clk_i);
    cs <= 0;
    for (k = 0; k < 9 && vld !== 1'b1; k++) @(negedge clk_i);
    if (k == 9) n_fail++;
    `CHK("pos", h[9:5], pos)
    `CHK("neg", h[4:0], neg)
    `CHK("sgl", h[4:0] == 5'h10 || h[4:0] == 5'h0f, sgl)
    `CHK("tmp", h[9:0] == 10'h232, tmp)
    `CHK("ref", h[9:0] == 10'h2b6, rf)
    `CHK("bad", h[9:0] == 10'h3ff, bad)
    `CHK("bip", s[12], bip)
    `CHK("rp", s[11], rp)
    `CHK("rn", s[10], rn)
    `CHK("ib", s[9:8] == 2'h3, ib)
    `CHK("rsel", s[5:4], rsel)
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(48715));
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 8; i++) sm[i] = 16'h1000;
    for (i = 0; i < 16; i++) cm[i] = i ? 16'h0001 : 16'h8001;
    rall;
    $display("test 1 reset values done");
    // Second round rewrites setups already in use
    repeat (2)
    begin
      for (i = 0; i < 8; i++)
      begin
        d = 16'($urandom) & 16'h1f30;
        d[9:8] = {2{d[8]}};
        d[5:4] = d[5] ? d[5:4] : 2'h0;
        wr(8'(8'h80 + 4 * i), d);
      end
      for (i = 0; i < 16; i++)
        wr(8'(8'h40 + 4 * i), (16'($urandom) & 16'hf000) | cd[i % 8]);
      rall;
      for (i = 0; i < 16; i++) cv(4'(i));
    end
    $display("test 2 setups and conversions done");
    wb(1, 8'h80, 16'h0330, 4'hc);
    `CHK("err", 1'b0, f)
    wb(0, 8'h00, 16'h0, 4'hf);
    `CHK("err", 1'b1, f)
    wb(1, 8'ha0, 16'h1000, 4'hf);
    `CHK("err", 1'b1, f)
    rall;
    $display("test 3 refusals done");
    end_sim;
  end

  // Watchdog, about thirteen times the expected run
  initial
  begin
    #1000000;
    n_fail++;
    end_sim;
  end
endmodule // adc_channel_input_and_setup_config_test
